/* File: logic/bce_pkg.sv */
package bce_pkg;

    // ------------------------------------------------------------
    // Decoded operation classes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_OTHER    = 3'h0,
        OP_JUMP     = 3'h1,
        OP_CALL     = 3'h2,
        OP_JUMP_REG = 3'h3,
        OP_CALL_REG = 3'h4,
        OP_JZ       = 3'h5,
        OP_JNZ      = 3'h6,
        OP_PREFIX   = 3'h7
    } bce_op_t;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam logic [3:0]         BCE_COND_AL    = 4'hE;
    localparam logic [3:0]         BCE_LINK_REG   = 4'hE;
    localparam logic [3:0]         BCE_LOW_REG_MAX = 4'h7;
    localparam logic [2:0]         BCE_BLOCK_MAX  = 3'h4;
    localparam logic signed [31:0] BCE_NEAR_SPAN  = 32'sh0010_0000;
    localparam logic signed [31:0] BCE_FAR_SPAN   = 32'sh0100_0000;
    localparam logic signed [31:0] BCE_CZ_MIN     = 32'sh0000_0004;
    localparam logic signed [31:0] BCE_CZ_MAX     = 32'sh0000_0082;
    localparam logic [31:0]        BCE_STEP_NARROW = 32'h0000_0002;
    localparam logic [31:0]        BCE_STEP_WIDE  = 32'h0000_0004;
    localparam int                 BCE_FLAG_N     = 3;
    localparam int                 BCE_FLAG_Z     = 2;
    localparam int                 BCE_FLAG_C     = 1;
    localparam int                 BCE_FLAG_V     = 0;
    localparam int                 BCE_BLK_W      = 11;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] base;
        logic [3:0] inv;
        logic [2:0] left;
    } bce_blk_t;

    typedef struct packed {
        logic                 redirect;
        logic [31:0]          pc;
        logic                 link_we;
        logic [31:0]          link;
        logic                 trap_state;
        logic                 trap_decode;
        logic                 exec_en;
        logic [BCE_BLK_W-1:0] saved;
    } bce_top_t;

    // Condition test on {N,Z,C,V}; codes 111x always pass
    function automatic logic bce_cond_pass(input logic [3:0] c, input logic [3:0] f);
        logic r;
        r = 1'b1;
        case (c[3:1])
            3'h0: r = f[BCE_FLAG_Z];
            3'h1: r = f[BCE_FLAG_C];
            3'h2: r = f[BCE_FLAG_N];
            3'h3: r = f[BCE_FLAG_V];
            3'h4: r = f[BCE_FLAG_C] & ~f[BCE_FLAG_Z];
            3'h5: r = (f[BCE_FLAG_N] == f[BCE_FLAG_V]);
            3'h6: r = ~f[BCE_FLAG_Z] & (f[BCE_FLAG_N] == f[BCE_FLAG_V]);
            default: r = 1'b1;
        endcase
        if ((c[3:1] != 3'h7) && c[0]) begin
            r = ~r;
        end
        return r;
    endfunction

endpackage

/* File: logic/bce_blk_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bce_blk_if;
    import bce_pkg::*;
    logic                 load;
    logic                 advance;
    logic                 flush;
    logic                 save;
    logic                 restore;
    logic [3:0]           base;
    logic [2:0]           inv;
    logic [2:0]           len;
    logic [BCE_BLK_W-1:0] restore_state;
    logic [BCE_BLK_W-1:0] saved_state;
    logic                 active;
    logic [3:0]           cur_cond;

    modport ctl (
        output load, advance, flush, save, restore, base, inv, len, restore_state,
        input  saved_state, active, cur_cond
    );
    modport blk (
        input  load, advance, flush, save, restore, base, inv, len, restore_state,
        output saved_state, active, cur_cond
    );
endinterface
`default_nettype wire

/* File: logic/bce_block_state.sv */
`timescale 1ns/1ps
`default_nettype none
module bce_block_state (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Control from the branch unit
    bce_blk_if.blk    blk
);
    import bce_pkg::*;

    bce_blk_t r;
    bce_blk_t nxt;

    // ------------------------------------------------------------
    // Predicated block tracking
    // ------------------------------------------------------------
    always_comb begin
        nxt = r;
        if (blk.restore) begin
            nxt = bce_blk_t'(blk.restore_state);
        end else if (blk.save || blk.flush) begin
            nxt = '0;
        end else if (blk.load) begin
            nxt.base = blk.base;
            nxt.inv  = {blk.inv, 1'b0};
            nxt.left = blk.len;
        end else if (blk.advance && (r.left != 3'h0)) begin
            nxt.inv  = r.inv >> 1;
            nxt.left = r.left - 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign blk.active      = (r.left != 3'h0);
    assign blk.cur_cond    = {r.base[3:1], r.base[0] ^ r.inv[0]};
    assign blk.saved_state = r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BLOCK_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (blk.load && !blk.restore && !blk.save && !blk.flush)
        |=> (r.left == $past(blk.len)) && (r.left <= BCE_BLOCK_MAX))
        else $error("block length not loaded from prefix");
    AST_SLOT_SENSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (blk.load && !blk.restore && !blk.save && !blk.flush)
        ##1 (blk.advance && !blk.restore && !blk.save && !blk.flush && !blk.load)
        |=> (blk.cur_cond[0] == ($past(blk.base[0], 2) ^ $past(blk.inv[0], 2))))
        else $error("second slot condition sense wrong");
endmodule
`default_nettype wire

/* File: logic/bce_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bce_top (
    // Clock and reset
    input  wire logic                      CLK_SYS_I,
    input  wire logic                      RESET_N_I,
    // Decoded instruction
    input  wire logic                      INSN_VALID_I,
    input  wire bce_pkg::bce_op_t          INSN_OP_I,
    input  wire logic [3:0]                INSN_COND_I,
    input  wire logic [31:0]               INSN_ADDR_I,
    input  wire logic                      INSN_WIDE_I,
    input  wire logic [31:0]               INSN_DISP_I,
    input  wire logic [2:0]                PREFIX_LEN_I,
    input  wire logic [2:0]                PREFIX_INV_I,
    // Operands and flags
    input  wire logic [31:0]               TARGET_REG_VAL_I,
    input  wire logic [3:0]                OPERAND_REG_IDX_I,
    input  wire logic [31:0]               OPERAND_REG_VAL_I,
    input  wire logic [3:0]                FLAGS_I,
    // Exception entry and return
    input  wire logic                      EXC_ENTRY_I,
    input  wire logic                      EXC_RETURN_I,
    input  wire logic [bce_pkg::BCE_BLK_W-1:0] EXC_STATE_I,
    // Program counter and link
    output logic                           REDIRECT_O,
    output logic [31:0]                    REDIRECT_PC_O,
    output logic                           LINK_WE_O,
    output logic [31:0]                    LINK_DATA_O,
    // Traps and status
    output logic                           TRAP_STATE_O,
    output logic                           TRAP_DECODE_O,
    output logic                           EXEC_EN_O,
    output logic [bce_pkg::BCE_BLK_W-1:0]  SAVED_STATE_O
);
    import bce_pkg::*;

    bce_top_t          r;
    bce_top_t          nxt;
    bce_blk_if         blk ();

    logic              go;
    logic              in_blk;
    logic [3:0]        eff_cond;
    logic              pass;
    logic              is_dir;
    logic              is_reg;
    logic              is_call;
    logic              is_cz;
    logic              cz_hit;
    logic              near_ok;
    logic              far_ok;
    logic              cz_ok;
    logic              bad_dec;
    logic              bad_state;
    logic              take;
    logic [31:0]       tgt;
    logic [31:0]       next_addr;
    logic signed [31:0] sd;

    // ------------------------------------------------------------
    // Predicated block state
    // ------------------------------------------------------------
    bce_block_state u_blk (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RESET_N_I),
        .blk     (blk)
    );

    // ------------------------------------------------------------
    // Decode and condition
    // ------------------------------------------------------------
    always_comb begin
        go       = INSN_VALID_I && !EXC_ENTRY_I;
        in_blk   = blk.active;
        sd       = $signed(INSN_DISP_I);
        is_dir   = (INSN_OP_I == OP_JUMP) || (INSN_OP_I == OP_CALL);
        is_reg   = (INSN_OP_I == OP_JUMP_REG) || (INSN_OP_I == OP_CALL_REG);
        is_call  = (INSN_OP_I == OP_CALL) || (INSN_OP_I == OP_CALL_REG);
        is_cz    = (INSN_OP_I == OP_JZ) || (INSN_OP_I == OP_JNZ);
        // Only the direct jump carries its own condition outside a block
        if (in_blk) begin
            eff_cond = blk.cur_cond;
        end else if (INSN_OP_I == OP_JUMP) begin
            eff_cond = INSN_COND_I;
        end else begin
            eff_cond = BCE_COND_AL;
        end
        // Flags are only read here, never written back
        pass     = bce_cond_pass(eff_cond, FLAGS_I);
        if (INSN_OP_I == OP_JZ) begin
            cz_hit = (OPERAND_REG_VAL_I == 32'h0000_0000);
        end else begin
            cz_hit = (OPERAND_REG_VAL_I != 32'h0000_0000);
        end
        near_ok  = (sd >= -BCE_NEAR_SPAN) && (sd < BCE_NEAR_SPAN);
        far_ok   = (sd >= -BCE_FAR_SPAN) && (sd < BCE_FAR_SPAN);
        cz_ok    = (sd >= BCE_CZ_MIN) && (sd <= BCE_CZ_MAX);
        bad_dec  = 1'b0;
        if ((INSN_OP_I == OP_JUMP) && (INSN_COND_I != BCE_COND_AL) && !in_blk
            && !near_ok) begin
            bad_dec = 1'b1;
        end
        if (is_dir && !far_ok) begin
            bad_dec = 1'b1;
        end
        if (is_cz && ((OPERAND_REG_IDX_I > BCE_LOW_REG_MAX) || !cz_ok || in_blk)) begin
            bad_dec = 1'b1;
        end
        if ((INSN_OP_I == OP_PREFIX) && ((PREFIX_LEN_I == 3'h0)
            || (PREFIX_LEN_I > BCE_BLOCK_MAX) || in_blk)) begin
            bad_dec = 1'b1;
        end
        bad_state = is_reg && pass && !TARGET_REG_VAL_I[0];
        take      = go && !bad_dec && !bad_state
                    && ((pass && (is_dir || is_reg)) || (is_cz && cz_hit));
        if (is_reg) begin
            tgt = {TARGET_REG_VAL_I[31:1], 1'b0};
        end else begin
            tgt = INSN_ADDR_I + INSN_DISP_I;
        end
        next_addr = INSN_ADDR_I + (INSN_WIDE_I ? BCE_STEP_WIDE : BCE_STEP_NARROW);
    end

    // ------------------------------------------------------------
    // Block control
    // ------------------------------------------------------------
    assign blk.load          = go && (INSN_OP_I == OP_PREFIX) && !bad_dec;
    assign blk.advance       = go && (INSN_OP_I != OP_PREFIX) && in_blk;
    assign blk.flush         = take;
    assign blk.save          = EXC_ENTRY_I;
    assign blk.restore       = EXC_RETURN_I;
    assign blk.base          = INSN_COND_I;
    assign blk.inv           = PREFIX_INV_I;
    assign blk.len           = PREFIX_LEN_I;
    assign blk.restore_state = EXC_STATE_I;

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    always_comb begin
        nxt             = r;
        nxt.redirect    = take;
        nxt.pc          = take ? tgt : r.pc;
        nxt.link_we     = take && is_call;
        nxt.link        = (take && is_call) ? next_addr : r.link;
        nxt.trap_state  = go && !bad_dec && bad_state;
        nxt.trap_decode = go && bad_dec;
        nxt.exec_en     = go && !bad_dec && pass;
        nxt.saved       = EXC_ENTRY_I ? blk.saved_state : r.saved;
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign REDIRECT_O    = r.redirect;
    assign REDIRECT_PC_O = r.pc;
    assign LINK_WE_O     = r.link_we;
    assign LINK_DATA_O   = r.link;
    assign TRAP_STATE_O  = r.trap_state;
    assign TRAP_DECODE_O = r.trap_decode;
    assign EXEC_EN_O     = r.exec_en;
    assign SAVED_STATE_O = r.saved;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);

    AST_REDIRECT_PC: assert property (
        take |=> REDIRECT_O && (REDIRECT_PC_O == $past(tgt)))
        else $error("taken branch did not redirect to its target");
    AST_LINK_WRITE: assert property (
        (take && is_call) |=> LINK_WE_O
        && (LINK_DATA_O == $past(INSN_ADDR_I) + ($past(INSN_WIDE_I) ? 32'h4 : 32'h2)))
        else $error("call did not write return address");
    AST_STATE_TRAP: assert property (
        (go && is_reg && pass && !TARGET_REG_VAL_I[0] && !bad_dec)
        |=> TRAP_STATE_O && !REDIRECT_O && !LINK_WE_O)
        else $error("clear target bit did not trap");
    AST_EVEN_TARGET: assert property (
        (take && is_reg) |=> (REDIRECT_PC_O[0] == 1'b0)
        && (REDIRECT_PC_O[31:1] == $past(TARGET_REG_VAL_I[31:1])))
        else $error("indirect target not formed from register");
    AST_NEAR_RANGE: assert property (
        (go && (INSN_OP_I == OP_JUMP) && (INSN_COND_I != BCE_COND_AL) && !in_blk
        && ((sd >= BCE_NEAR_SPAN) || (sd < -BCE_NEAR_SPAN)))
        |=> TRAP_DECODE_O && !REDIRECT_O)
        else $error("conditional jump beyond short range accepted");
    AST_FAR_RANGE: assert property (
        (go && is_dir && (sd >= BCE_FAR_SPAN)) |=> TRAP_DECODE_O && !REDIRECT_O)
        else $error("direct branch beyond long range accepted");
    AST_ZERO_TEST: assert property (
        (go && (INSN_OP_I == OP_JZ) && !bad_dec)
        |=> (REDIRECT_O == ($past(OPERAND_REG_VAL_I) == 32'h0)))
        else $error("jump-if-zero outcome wrong");
    AST_NONZERO_TEST: assert property (
        (go && (INSN_OP_I == OP_JNZ) && !bad_dec)
        |=> (REDIRECT_O == ($past(OPERAND_REG_VAL_I) != 32'h0)))
        else $error("jump-if-nonzero outcome wrong");
    AST_LOW_REG: assert property (
        (go && is_cz && (OPERAND_REG_IDX_I > 4'h7)) |=> TRAP_DECODE_O && !REDIRECT_O)
        else $error("high operand register accepted");
    AST_CZ_WINDOW: assert property (
        (go && is_cz && ((sd < 32'sd4) || (sd > 32'sd130))) |=> TRAP_DECODE_O)
        else $error("zero-test target outside forward window");
    AST_FAIL_THROUGH: assert property (
        (go && (is_dir || is_reg) && !pass) |=> !REDIRECT_O && !LINK_WE_O)
        else $error("failed condition still branched or linked");
endmodule
`default_nettype wire

/* File: dv/bce_tb_pkg.sv */
package bce_tb_pkg;
    import bce_pkg::*;

    // One instruction with the pulses {redirect, link, trap_state, trap_decode, exec} it gives
    typedef struct packed {
        bce_op_t     op;
        logic [3:0]  cond;
        logic        wide;
        logic [31:0] disp;
        logic [2:0]  len;
        logic [2:0]  inv;
        logic [31:0] tgt;
        logic [3:0]  idx;
        logic [31:0] val;
        logic [3:0]  flags;
        logic [4:0]  exp;
    } bce_row_t;

endpackage

/* File: dv/bce_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bce_fetch_model
    import bce_pkg::*, bce_tb_pkg::*;
#(
    parameter logic [31:0] BASE_ADDR = 32'h0000_0000
)(
    // Instruction
    output var logic        valid_o,
    output var bce_op_t     op_o,
    output var logic [3:0]  cond_o,
    output var logic [31:0] addr_o,
    output var logic        wide_o,
    output var logic [31:0] disp_o,
    output var logic [2:0]  len_o,
    output var logic [2:0]  inv_o,
    // Operands and flags
    output var logic [31:0] tgt_o,
    output var logic [3:0]  idx_o,
    output var logic [31:0] val_o,
    output var logic [3:0]  flags_o
);
    // ------------------------------------------------------------
    // Decode stage
    // ------------------------------------------------------------
    initial begin
        {valid_o, cond_o, addr_o, wide_o, disp_o, len_o, inv_o} = '0;
        {tgt_o, idx_o, val_o, flags_o} = '0;
        op_o = OP_OTHER;
    end

    // Sequences keep branches last in a block and conditions legal
    task automatic issue(input bce_row_t r);
        valid_o = 1'b1;
        op_o    = r.op;
        cond_o  = r.cond;
        addr_o  = BASE_ADDR;
        wide_o  = r.wide;
        disp_o  = r.disp;
        len_o   = r.len;
        inv_o   = r.inv;
        tgt_o   = r.tgt;
        idx_o   = r.idx;
        val_o   = r.val;
        flags_o = r.flags;
    endtask

    // Released op, addr, disp, tgt and val show garbage; the other fields keep the last instruction
    task automatic idle();
        valid_o = 1'b0;
        op_o    = bce_op_t'(~op_o);
        addr_o  = ~addr_o;
        disp_o  = ~disp_o;
        tgt_o   = ~tgt_o;
        val_o   = ~val_o;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bce_pkg::*;
    import bce_tb_pkg::*;

    localparam logic [31:0] BASE = 32'h0200_0000;
    localparam logic [4:0]  E_NO = 5'h00;
    localparam logic [4:0]  E_EX = 5'h01;
    localparam logic [4:0]  E_TD = 5'h02;
    localparam logic [4:0]  E_TS = 5'h04;
    localparam logic [4:0]  E_RD = 5'h11;
    localparam logic [4:0]  E_CL = 5'h19;
    localparam logic [3:0]  AL   = BCE_COND_AL;
    localparam logic [3:0]  EQ   = 4'h0;
    localparam logic [3:0]  NE   = 4'h1;
    localparam logic [3:0]  Z    = 4'h4;

    logic                 clk_sys;
    logic                 rst_n;
    logic                 valid;
    bce_op_t              op;
    logic [3:0]           cond;
    logic [31:0]          addr;
    logic                 wide;
    logic [31:0]          disp;
    logic [2:0]           plen;
    logic [2:0]           pinv;
    logic [31:0]          tgt;
    logic [3:0]           idx;
    logic [31:0]          val;
    logic [3:0]           flags;
    logic                 exc_entry;
    logic                 exc_return;
    logic [BCE_BLK_W-1:0] exc_state;
    logic                 redirect;
    logic [31:0]          redirect_pc;
    logic                 link_we;
    logic [31:0]          link_data;
    logic                 trap_state;
    logic                 trap_decode;
    logic                 exec_en;
    logic [BCE_BLK_W-1:0] saved_state;
    int                   num_errors = 0;
    int                   comparisons = 0;
    bce_row_t             rows[$];

    bce_fetch_model #(.BASE_ADDR(BASE)) u_bce_fetch_model (
        .valid_o(valid), .op_o(op), .cond_o(cond), .addr_o(addr), .wide_o(wide),
        .disp_o(disp), .len_o(plen), .inv_o(pinv), .tgt_o(tgt), .idx_o(idx),
        .val_o(val), .flags_o(flags)
    );

    bce_top u_bce_top (
        .CLK_SYS_I(clk_sys), .RESET_N_I(rst_n), .INSN_VALID_I(valid), .INSN_OP_I(op),
        .INSN_COND_I(cond), .INSN_ADDR_I(addr), .INSN_WIDE_I(wide), .INSN_DISP_I(disp),
        .PREFIX_LEN_I(plen), .PREFIX_INV_I(pinv), .TARGET_REG_VAL_I(tgt),
        .OPERAND_REG_IDX_I(idx), .OPERAND_REG_VAL_I(val), .FLAGS_I(flags),
        .EXC_ENTRY_I(exc_entry), .EXC_RETURN_I(exc_return), .EXC_STATE_I(exc_state),
        .REDIRECT_O(redirect), .REDIRECT_PC_O(redirect_pc), .LINK_WE_O(link_we),
        .LINK_DATA_O(link_data), .TRAP_STATE_O(trap_state), .TRAP_DECODE_O(trap_decode),
        .EXEC_EN_O(exec_en), .SAVED_STATE_O(saved_state)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic bce_row_t mk(input bce_op_t op, input logic [3:0] c, input logic w,
        input logic [31:0] d, input logic [31:0] t, input logic [3:0] i,
        input logic [31:0] v, input logic [3:0] f, input logic [4:0] e);
        return '{op, c, w, d, 3'h0, 3'h0, t, i, v, f, e};
    endfunction

    function automatic bce_row_t pf(input logic [3:0] c, input logic [2:0] l,
        input logic [2:0] iv, input logic [4:0] e);
        return '{OP_PREFIX, c, 1'b0, 32'h0, l, iv, 32'h0, 4'h0, 32'h0, Z, e};
    endfunction

    function automatic bce_row_t o(input logic [3:0] f, input logic [4:0] e);
        return mk(OP_OTHER, AL, 1'b0, 32'h0, 32'h0, 4'h0, 32'h0, f, e);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Trapped rows and the prefix itself leave the exec pulse unchecked
    task automatic run(input bce_row_t r);
        logic [31:0] pc;
        logic [4:0]  m;
        logic [4:0]  seen;
        u_bce_fetch_model.issue(r);
        @(posedge clk_sys);
        @(negedge clk_sys);
        seen = {redirect, link_we, trap_state, trap_decode, exec_en};
        m    = (r.exp[2] || r.exp[1] || r.op == OP_PREFIX) ? 5'h1E : 5'h1F;
        pc   = BASE + r.disp;
        if (r.op inside {OP_JUMP_REG, OP_CALL_REG}) begin
            pc = r.tgt & 32'hFFFF_FFFE;
        end
        check("pulses", 32'(seen & m), 32'(r.exp & m));
        if (r.exp[4]) begin
            check("target", redirect_pc, pc);
        end
        if (r.exp[3]) begin
            check("link", link_data, BASE + (r.wide ? 32'h4 : 32'h2));
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        $display("ERROR watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        {rst_n, exc_entry, exc_return, exc_state} = '0;
        repeat (16) @(negedge clk_sys);
        check("reset", 32'({redirect, link_we, trap_state, trap_decode, exec_en}), 32'h0);
        check("reset pc", redirect_pc ^ link_data, 32'h0);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check("after reset", 32'({redirect, link_we, exec_en, saved_state}), 32'h0);
        $display("Test reset done");
        rows.push_back(mk(OP_JUMP, AL, 1'b0, 32'h10, '0, 4'h0, '0, 4'h0, E_RD));
        rows.push_back(mk(OP_JUMP, EQ, 1'b1, 32'h000F_FFFE, '0, 4'h0, '0, Z, E_RD));
        rows.push_back(mk(OP_JUMP, EQ, 1'b1, 32'hFFF0_0000, '0, 4'h0, '0, Z, E_RD));
        rows.push_back(mk(OP_JUMP, EQ, 1'b1, 32'h0010_0000, '0, 4'h0, '0, Z, E_TD));
        rows.push_back(mk(OP_JUMP, EQ, 1'b1, 32'h40, '0, 4'h0, '0, 4'h0, E_NO));
        rows.push_back(mk(OP_JUMP, AL, 1'b1, 32'h00FF_FFFE, '0, 4'h0, '0, 4'h0, E_RD));
        rows.push_back(mk(OP_JUMP, AL, 1'b1, 32'h0100_0000, '0, 4'h0, '0, 4'h0, E_TD));
        rows.push_back(mk(OP_CALL, AL, 1'b1, 32'hFF00_0000, '0, 4'h0, '0, 4'h0, E_CL));
        rows.push_back(mk(OP_CALL, AL, 1'b1, 32'h0100_0000, '0, 4'h0, '0, 4'h0, E_TD));
        rows.push_back(mk(OP_JUMP_REG, AL, 1'b0, '0, 32'h2001, 4'h0, '0, 4'h0, E_RD));
        rows.push_back(mk(OP_JUMP_REG, AL, 1'b0, '0, 32'h2000, 4'h0, '0, 4'h0, E_TS));
        rows.push_back(mk(OP_CALL_REG, AL, 1'b0, '0, 32'h3003, 4'h0, '0, 4'h0, E_CL));
        rows.push_back(mk(OP_CALL_REG, AL, 1'b0, '0, 32'h3002, 4'h0, '0, 4'h0, E_TS));
        rows.push_back(mk(OP_JZ, AL, 1'b0, 32'h4, '0, 4'h7, 32'h0, 4'h0, E_RD));
        rows.push_back(mk(OP_JZ, AL, 1'b0, 32'h82, '0, 4'h0, 32'h5, Z, E_EX));
        rows.push_back(mk(OP_JNZ, AL, 1'b0, 32'h82, '0, 4'h3, 32'h5, 4'h0, E_RD));
        rows.push_back(mk(OP_JNZ, AL, 1'b0, 32'h4, '0, 4'h3, 32'h0, 4'h0, E_EX));
        rows.push_back(mk(OP_JZ, AL, 1'b0, 32'h4, '0, 4'h8, 32'h0, 4'h0, E_TD));
        rows.push_back(mk(OP_JZ, AL, 1'b0, 32'h2, '0, 4'h1, 32'h0, 4'h0, E_TD));
        rows.push_back(mk(OP_JNZ, AL, 1'b0, 32'h84, '0, 4'h1, 32'h1, 4'h0, E_TD));
        rows.push_back(o(4'h0, E_EX));
        rows.push_back(pf(EQ, 3'h0, 3'h0, E_TD));
        rows.push_back(pf(EQ, 3'h5, 3'h0, E_TD));
        foreach (rows[k]) begin
            run(rows[k]);
        end
        $display("Test table done");
        run(pf(EQ, 3'h3, 3'b010, E_NO));
        run(o(Z, E_EX));
        run(o(Z, E_EX));
        run(o(Z, E_NO));
        run(o(Z, E_EX));
        run(pf(NE, 3'h4, 3'b111, E_NO));
        run(o(Z, E_NO));
        run(o(Z, E_EX));
        run(o(Z, E_EX));
        run(mk(OP_JUMP, EQ, 1'b1, 32'h0080_0000, '0, 4'h0, '0, Z, E_RD));
        run(pf(NE, 3'h1, 3'h0, E_NO));
        run(mk(OP_JUMP, NE, 1'b1, 32'h40, '0, 4'h0, '0, Z, E_NO));
        run(pf(NE, 3'h1, 3'h0, E_NO));
        run(mk(OP_CALL, AL, 1'b1, 32'h40, '0, 4'h0, '0, Z, E_NO));
        $display("Test block done");
        run(pf(EQ, 3'h3, 3'b010, E_NO));
        run(o(Z, E_EX));
        exc_entry = 1'b1;
        run(o(Z, E_NO));
        exc_entry = 1'b0;
        check("saved left", 32'(saved_state[2:0]), 32'h2);
        check("saved base", 32'(saved_state[10:7]), 32'(EQ));
        run(o(4'h0, E_EX));
        u_bce_fetch_model.idle();
        exc_state = saved_state;
        exc_return = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        exc_return = 1'b0;
        run(o(Z, E_EX));
        run(o(Z, E_NO));
        run(o(Z, E_EX));
        $display("Test exception done");
        end_of_test();
    end
endmodule
`default_nettype wire
